// ---- src/sram_host_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module sram_host_ctrl
  import sram_host_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // User request side.
  input wire logic req_valid,
  output logic req_ready,
  input wire host_req_t req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  // Memory pins.
  output sram_pins_t pins,
  input wire logic [DATA_W-1:0] shared_data_bus_in,
  output logic [DATA_W-1:0] shared_data_bus_out,
  output logic [LANES-1:0] shared_data_bus_oe
);

  // =====================================================================
  // State.
  // =====================================================================
  host_state_t state;
  host_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic last_write;
  logic next_last_write;
  sram_pins_t next_pins;
  logic [DATA_W-1:0] next_bus_out;
  logic [LANES-1:0] next_bus_oe;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_data;
  logic take;
  logic turn_needed;

  assign req_ready = (state == ST_IDLE);
  assign take = req_valid && req_ready;
  assign turn_needed = (req.write != last_write);

  // =====================================================================
  // Next-value logic.
  // =====================================================================
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_last_write = last_write;
    next_pins = pins;
    next_bus_out = shared_data_bus_out;
    next_bus_oe = shared_data_bus_oe;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    case (state)
      ST_IDLE:
      begin
        if (take && turn_needed)
        begin
          next_state = ST_TURN;
          next_cnt = '0;
          next_last_write = req.write;
        end
        else if (take)
        begin
          next_cnt = 3'h1;
          next_pins.word_address = req.addr;
          next_pins.chip_select_n = 1'b0;
          next_pins.low_lane_select_n = ~req.lanes[0];
          next_pins.high_lane_select_n = ~req.lanes[1];
          if (req.write)
          begin
            next_state = ST_WRITE;
            next_pins.write_enable_n = ~(|req.lanes);
            next_pins.output_enable_n = 1'b1;
            next_bus_out = req.wdata;
            next_bus_oe = req.lanes;
          end
          else
          begin
            next_state = ST_READ;
            next_pins.write_enable_n = 1'b1;
            next_pins.output_enable_n = 1'b0;
            next_bus_oe = '0;
          end
        end
      end
      ST_TURN:
      begin
        next_cnt = cnt + 3'h1;
        if (cnt == TURN_LAST)
        begin
          next_state = ST_IDLE;
        end
      end
      ST_READ:
      begin
        next_cnt = cnt + 3'h1;
        if (cnt == READ_LAST)
        begin
          next_state = ST_SPACE;
          next_cnt = 3'h1;
          next_rsp_valid = 1'b1;
          next_rsp_data = shared_data_bus_in;
          next_pins = PINS_IDLE;
          next_pins.word_address = pins.word_address;
        end
      end
      ST_WRITE:
      begin
        next_cnt = cnt + 3'h1;
        if (cnt == WRITE_LAST)
        begin
          next_state = ST_SPACE;
          next_cnt = 3'h1;
          next_rsp_valid = 1'b1;
          next_pins.write_enable_n = 1'b1;
          next_pins.chip_select_n = 1'b1;
          next_pins.low_lane_select_n = 1'b1;
          next_pins.high_lane_select_n = 1'b1;
        end
      end
      ST_SPACE:
      begin
        next_cnt = cnt + 3'h1;
        next_bus_oe = '0;
        if (cnt == SPACE_LAST)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_pins = PINS_IDLE;
        next_bus_oe = '0;
      end
    endcase
  end

  // =====================================================================
  // Registers.
  // =====================================================================
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      last_write <= 1'b0;
      pins <= PINS_IDLE;
      shared_data_bus_out <= DATA_RESET;
      shared_data_bus_oe <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= DATA_RESET;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      last_write <= next_last_write;
      pins <= next_pins;
      shared_data_bus_out <= next_bus_out;
      shared_data_bus_oe <= next_bus_oe;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  // =====================================================================
  // Checks.
  // =====================================================================
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_read_we_high: assert property ((state == ST_READ) |-> pins.write_enable_n)
    else $error("write enable low during read");
  chk_read_length: assert property ($rose(state == ST_READ) |-> (state == ST_READ) [*2])
    else $error("read cycle too short");
  chk_write_pulse: assert property ($fell(pins.write_enable_n) |-> !pins.write_enable_n [*2])
    else $error("write pulse too short");
  chk_write_lane: assert property (!pins.write_enable_n |->
    (!pins.chip_select_n && !(pins.low_lane_select_n && pins.high_lane_select_n)))
    else $error("write enable without select or lane");
  chk_write_end: assert property ($rose(pins.write_enable_n) |-> $rose(pins.chip_select_n))
    else $error("write end not at one edge");
  chk_addr_stable: assert property (!pins.write_enable_n && !$fell(pins.write_enable_n)
    |-> $stable(pins.word_address))
    else $error("address moved during write");
  chk_data_stable: assert property (!pins.write_enable_n && !$fell(pins.write_enable_n)
    |-> $stable(shared_data_bus_out))
    else $error("write data moved during write");
  chk_no_contention: assert property (!pins.output_enable_n |-> shared_data_bus_oe == '0)
    else $error("host drives bus while memory may drive");
  chk_write_spacing: assert property ($rose(pins.write_enable_n) |->
    pins.write_enable_n [*3])
    else $error("writes too close");
  chk_data_hold: assert property ($rose(pins.write_enable_n) |->
    $stable(shared_data_bus_out) && shared_data_bus_oe == $past(shared_data_bus_oe))
    else $error("write data not held at write end");

  // =====================================================================
  // Write cycle checks.
  // =====================================================================
  chk_write_oe_high: assert property (!pins.write_enable_n |->
    pins.output_enable_n)
    else $error("output enable low during write");

  chk_cs_before_end: assert property ($rose(pins.chip_select_n) && !$past(pins.write_enable_n) |->
    !$past(pins.chip_select_n, 2))
    else $error("select too short before write end");

  chk_addr_before_end: assert property ($rose(pins.write_enable_n) |->
    $past(pins.word_address) == $past(pins.word_address, 2))
    else $error("address too late before write end");

  chk_lane_before_end: assert property ($rose(pins.write_enable_n) |->
    $past(pins.low_lane_select_n) == $past(pins.low_lane_select_n, 2))
    else $error("low lane select too late before write end");

  chk_hlane_before_end: assert property ($rose(pins.write_enable_n) |->
    $past(pins.high_lane_select_n) == $past(pins.high_lane_select_n, 2))
    else $error("high lane select too late before write end");

  chk_lane_at_end: assert property ($rose(pins.write_enable_n) |->
    !($past(pins.low_lane_select_n) && $past(pins.high_lane_select_n)))
    else $error("no lane active at write end");

  chk_data_before_end: assert property ($rose(pins.write_enable_n) |->
    $past(shared_data_bus_out) == $past(shared_data_bus_out, 2))
    else $error("write data too late before write end");

  chk_drive_at_end: assert property ($rose(pins.write_enable_n) |->
    shared_data_bus_oe != '0)
    else $error("write data released before write end");

  chk_write_begin: assert property ($fell(pins.write_enable_n) |->
    $fell(pins.chip_select_n))
    else $error("write begins apart from select");

  chk_lane_match: assert property (!pins.write_enable_n |->
    shared_data_bus_oe == {!pins.high_lane_select_n, !pins.low_lane_select_n})
    else $error("driven lanes differ from lane selects");

  // =====================================================================
  // Read, spacing, turnaround, ready and response checks.
  // =====================================================================
  chk_read_pins: assert property ((state == ST_READ) |->
    !pins.output_enable_n && !pins.chip_select_n)
    else $error("read without select or output enable");

  chk_read_addr_hold: assert property ((state == ST_READ) && !$rose(state == ST_READ) |->
    $stable(pins.word_address))
    else $error("address moved during read");

  chk_read_end_pins: assert property ($rose(state == ST_SPACE) && !last_write |->
    pins.output_enable_n && pins.chip_select_n)
    else $error("read not closed after read cycle");

  chk_space_len: assert property ($rose(state == ST_SPACE) |->
    (state == ST_SPACE) [*2])
    else $error("spacing too short");

  chk_space_pins: assert property ((state == ST_SPACE) |->
    pins.chip_select_n && pins.write_enable_n)
    else $error("memory selected during spacing");

  chk_turn_len: assert property ($rose(state == ST_TURN) |->
    (state == ST_TURN) [*3])
    else $error("turnaround too short");

  chk_turn_pins: assert property ((state == ST_TURN) |->
    pins.chip_select_n && shared_data_bus_oe == '0)
    else $error("bus busy during turnaround");

  chk_ready_pins: assert property (req_ready |->
    pins.chip_select_n && pins.write_enable_n)
    else $error("ready while memory selected");

  chk_rsp_pulse: assert property (rsp_valid |->
    ##1 !rsp_valid)
    else $error("response longer than one cycle");

  // =====================================================================
  // Bus ownership checks and cover points.
  // =====================================================================
  chk_read_bus_free: assert property ((state == ST_READ) |->
    shared_data_bus_oe == '0)
    else $error("host drives bus during read");

  chk_bus_release: assert property ($rose(pins.write_enable_n) |->
    ##1 shared_data_bus_oe == '0)
    else $error("bus not released after write");

  chk_drive_in_write: assert property (shared_data_bus_oe != '0 |->
    !pins.write_enable_n || $rose(pins.write_enable_n))
    else $error("host drives bus outside a write");

  cov_read: cover property ($rose(rsp_valid) && pins.write_enable_n && last_write == 1'b0);
  cov_write: cover property ($rose(pins.write_enable_n));
  cov_turn: cover property (state == ST_TURN ##1 state == ST_TURN);
  cov_byte_write: cover property (!pins.write_enable_n && pins.high_lane_select_n);

endmodule
`default_nettype wire

// ---- src/sram_host_pkg.sv ----
// Operation
// - Write enable stays high for every read access.
// - A write ends at the first of select or write enable going high.
// - Write pulse with output enable high lasts at least 7, 8 or 9 ns.
// - Write pulse with output enable low lasts at least 10, 12 or 15 ns.
// - Address and select stand at least 7, 8 or 9 ns before write end.
// - Address is valid before the write begins and holds until it ends; the code sets it at the same clock edge as write enable falls.
// - Lane selects are active at least 7, 8 or 9 ns before write end.
// - Write data stands at least 5, 6 or 7 ns before write end.
// - Write data and address hold at least 0 ns after write end.
// - The host avoids driving the data bus while the memory drives it.
package sram_host_pkg;

  // =====================================================================
  // Clock and timing, slowest grade (15 ns part) so every grade is met.
  // =====================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_READ_CYCLE_NS = 15;
  localparam int T_WRITE_CYCLE_NS = 15;
  localparam int T_WRITE_PULSE_OE_LOW_NS = 15;
  localparam int T_DATA_SETUP_NS = 7;
  localparam int T_FLOAT_NS = 7;
  localparam int T_LOW_Z_NS = 3;

  localparam int READ_CYCLES = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (T_WRITE_PULSE_OE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPACE_CYCLES = (T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYCLES = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYCLES = FLOAT_CYCLES + (T_LOW_Z_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;

  localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(READ_CYCLES);
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYCLES);
  localparam logic [CNT_W-1:0] SPACE_LAST = CNT_W'(SPACE_CYCLES);
  localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(TURN_CYCLES);

  // =====================================================================
  // Memory shape.
  // =====================================================================
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_SPACE = 3'b011,
    ST_TURN = 3'b100
  } host_state_t;

  typedef struct packed
  {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] lanes;
  } host_req_t;

  typedef struct packed
  {
    logic chip_select_n;
    logic write_enable_n;
    logic output_enable_n;
    logic low_lane_select_n;
    logic high_lane_select_n;
    logic [ADDR_W-1:0] word_address;
  } sram_pins_t;

  localparam sram_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_RESET};

endpackage

// ---- testbench/sram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sram_model
  import sram_host_pkg::*;
(
  // Memory pins.
  input wire sram_pins_t pins,
  input wire logic [DATA_W-1:0] bus,
  // Read drive towards the bus.
  output logic [LANES-1:0] drv_en,
  output logic [DATA_W-1:0] drv_data
);
  // ==========================================
  // Array and write capture.
  // ==========================================
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [LANES-1:0] rd_on;
  logic [LANES-1:0] wl;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic wr_prev = 1'b0;
  logic late_cs = 1'b0;
  wire logic lanes_off = pins.low_lane_select_n && pins.high_lane_select_n;
  wire logic wr_now = !pins.chip_select_n && !pins.write_enable_n && !lanes_off;

  always @(pins.chip_select_n)
    late_cs = !pins.chip_select_n && !pins.write_enable_n;

  always @(pins or bus or wr_now)
  begin
    if (wr_prev && !wr_now)
    begin
      if (!wl[0]) mem[wa][7:0] = wd[7:0];
      if (!wl[1]) mem[wa][15:8] = wd[15:8];
    end
    if (wr_now)
    begin
      wa = pins.word_address;
      wd = bus;
      wl = {pins.high_lane_select_n, pins.low_lane_select_n};
    end
    wr_prev = wr_now;
  end

  // ==========================================
  // Read drive with turn-on and float delays.
  // ==========================================
  wire logic rd = !pins.chip_select_n && !pins.output_enable_n && pins.write_enable_n && !late_cs;
  assign rd_on = {rd && !pins.high_lane_select_n, rd && !pins.low_lane_select_n};
  assign #3 drv_en = rd_on;
  assign #3 drv_data = mem[pins.word_address];
endmodule
`default_nettype wire

// ---- testbench/async_sram_64k_x16_port_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module async_sram_64k_x16_port_tb
  import sram_host_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  host_req_t req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  sram_pins_t pins;
  sram_pins_t pp = PINS_IDLE;
  wire logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] bus_out;
  logic [DATA_W-1:0] po = '0;
  logic [DATA_W-1:0] prev_bus = 16'h0000;
  logic [DATA_W-1:0] drv_data;
  logic [LANES-1:0] bus_oe;
  logic [LANES-1:0] drv_en;
  logic [DATA_W-1:0] q;
  int num_errors = 0;
  int samples_checked = 0;
  int we_len = 0;

  always #5 core_clk = ~core_clk;

  sram_host_ctrl sram_host_ctrl_i (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .shared_data_bus_in(bus), .shared_data_bus_out(bus_out), .shared_data_bus_oe(bus_oe));
  sram_model sram_model_i (.pins(pins), .bus(bus), .drv_en(drv_en), .drv_data(drv_data));

  // ==========================================
  // Wire level: a released lane shows the inverse of its last level.
  // ==========================================
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign bus[8*i+:8] = bus_oe[i] ? bus_out[8*i+:8] : (drv_en[i] ? drv_data[8*i+:8] : ~prev_bus[8*i+:8]);
  end

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [LANES-1:0] ln);
    int n;
    n = 0;
    req = '{wr, a, d, ln};
    req_valid = 1'b1;
    @(negedge core_clk);
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    check({15'h0, rsp_valid}, 16'h0001);
    q = rsp_data;
    req_valid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    access(1'b0, a, 16'h0000, 2'b11);
    check(q, exp);
  endtask

  // ==========================================
  // Pin monitor.
  // ==========================================
  always @(posedge core_clk)
  begin
    prev_bus <= bus;
    pp <= pins;
    po <= bus_out;
    if (resetn)
    begin
      if (!pins.output_enable_n) check({15'h0, pins.write_enable_n}, 16'h0001);
      check({14'h0, bus_oe & drv_en}, 16'h0000);
      if (!pins.write_enable_n && !pp.write_enable_n) check(pins.word_address, pp.word_address);
      if (!pins.write_enable_n && !pp.write_enable_n) check(bus_out, po);
      if (!pins.write_enable_n) we_len <= we_len + 1;
      if (pins.write_enable_n && !pp.write_enable_n)
      begin
        check({15'h0, we_len >= 2}, 16'h0001);
        check(bus_out, po);
        we_len <= 0;
      end
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end

  // ==========================================
  // Scenarios.
  // ==========================================
  initial
  begin
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    check({7'h0, pins[20:16], bus_oe, rsp_valid, req_ready}, 16'h01f1);
    access(1'b1, 16'hffff, 16'ha55a, 2'b11);
    access(1'b1, 16'h0000, 16'h5aa5, 2'b11);
    rd(16'hffff, 16'ha55a);
    rd(16'h0000, 16'h5aa5);
    access(1'b1, 16'h0010, 16'h1111, 2'b11);
    access(1'b1, 16'h0010, 16'h22ee, 2'b01);
    access(1'b1, 16'h0010, 16'h3344, 2'b10);
    access(1'b1, 16'h0010, 16'h9999, 2'b00);
    rd(16'h0010, 16'h33ee);
    conclude();
  end
endmodule
`default_nettype wire
